// >>> rtl/mcu_bus_params.svh
// Purpose: shared constants of the host bus port and its controller
// Assumes: included once per file by bare name
// Notes: cycle counts are at the 50 MHz system clock
`ifndef MCU_BUS_PARAMS_SVH
`define MCU_BUS_PARAMS_SVH
`define ADDR_W       20
`define AD_W         16
`define XA_W         4
`define MEM_AW_DEF   6
`define MEM_BASE_DEF 20'h00000
`define WARM_DONE    2'h3
`define H_ADR_CYC    4'h3
`define H_HOLD_CYC   4'h3
`define H_STB_CYC    4'h8
`define H_REC_CYC    4'h3
`define R_CFG        3'h0
`define R_ADDR_LO    3'h1
`define R_ADDR_HI    3'h2
`define R_WDATA      3'h3
`define R_CMD        3'h4
`define R_RDATA      3'h5
`define R_STATUS     3'h6
`define PAGE_MASK    20'hfff00
`define BURST_MASK   20'hffff0
`define PULL_UP      8'hff
`endif

// >>> rtl/mcu_bus_pkg.sv
// Purpose: types shared by both ends of the host bus
// Assumes: nothing
// Notes: device configuration is fixed at reset release; the host reloads its copy through R_CFG while idle
`default_nettype none
package mcu_bus_pkg;
	typedef struct packed {
		logic dir_en;      // 1: direction + enable, 0: separate strobes
		logic mux;         // address and data share the address/data port
		logic page;        // page mode, data on the high byte
		logic burst;       // burst mode, low nibble on port A
		logic dual_read;   // program fetch strobe on control pin two
		logic addr_out_en; // show latched address on port B
		logic addr_out_hi; // port B shows A15-A8 instead of A7-A0
	} cfg_s;
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_ADR  = 3'b001,
		H_HOLD = 3'b010,
		H_STB  = 3'b011,
		H_REC  = 3'b100
	} host_st_e;
endpackage
`default_nettype wire

// >>> rtl/mcu_bus_if.sv
// Purpose: pins between the host controller and the device port
// Assumes: undriven bytes float high through a pull-up
// Notes: pin levels are resolved here from the enables
`default_nettype none
`include "mcu_bus_params.svh"
interface mcu_bus_if;
	logic               control_pin_zero;
	logic               control_pin_one;
	logic               control_pin_two;
	logic               address_strobe;
	logic [`XA_W-1:0]   extra_addr;
	logic [`AD_W-1:0]   ad_host;
	logic [1:0]         ad_host_oe_n;
	logic [`AD_W-1:0]   ad_dev;
	logic [1:0]         ad_dev_oe_n;
	logic [7:0]         pa_host;
	logic [7:0]         pa_host_oe_n;
	logic [7:0]         pa_dev;
	logic               pa_dev_oe_n;
	logic [7:0]         port_b;
	logic               port_b_oe_n;
	logic [`AD_W-1:0]   address_data_port;
	logic [7:0]         port_a;
	// device wins a byte it drives, then host, else pull-up
	always_comb
	begin
		for (int b = 0; b < 2; b++)
			address_data_port[b*8 +: 8] = !ad_dev_oe_n[b] ? ad_dev[b*8 +: 8] :
				!ad_host_oe_n[b] ? ad_host[b*8 +: 8] : `PULL_UP;
		for (int i = 0; i < 8; i++)
			port_a[i] = !pa_dev_oe_n ? pa_dev[i] : !pa_host_oe_n[i] ? pa_host[i] : 1'b1;
	end
	modport dev (
		input  control_pin_zero, control_pin_one, control_pin_two, address_strobe,
		input  extra_addr, address_data_port, port_a,
		output ad_dev, ad_dev_oe_n, pa_dev, pa_dev_oe_n, port_b, port_b_oe_n
	);
	modport host (
		output control_pin_zero, control_pin_one, control_pin_two, address_strobe,
		output extra_addr, ad_host, ad_host_oe_n, pa_host, pa_host_oe_n,
		input  address_data_port, port_a
	);
endinterface
`default_nettype wire

// >>> rtl/mcu_bus_port.sv
// Purpose: device end of the host bus, with a small internal byte memory
// Assumes: all pins come from outside and are synchronised in two flops
// Notes: straps are caught once, so a new bus type needs a reset
`default_nettype none
`include "mcu_bus_params.svh"
module mcu_bus_port #(
	parameter int                 MEM_AW = `MEM_AW_DEF,
	parameter logic [`ADDR_W-1:0] BASE   = `MEM_BASE_DEF
) (
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	input  wire logic               clk_en,
	input  wire mcu_bus_pkg::cfg_s  cfg_strap,
	mcu_bus_if.dev                  bus,
	output logic                    array_input,
	output logic                    ext_rd_n,
	output logic                    ext_wr_n
);
	typedef struct packed {
		logic [1:0]                  warm;
		mcu_bus_pkg::cfg_s           cfg;
		logic [2:0]                  ctl_s1;
		logic [2:0]                  ctl_s2;
		logic                        as_s1;
		logic                        as_s2;
		logic [`AD_W-1:0]            ad_s1;
		logic [`AD_W-1:0]            ad_s2;
		logic [7:0]                  pa_s1;
		logic [7:0]                  pa_s2;
		logic [`XA_W-1:0]            xa_s1;
		logic [`XA_W-1:0]            xa_s2;
		logic [`AD_W-1:0]            alat;
		logic [`XA_W-1:0]            xlat;
		logic                        wr_q;
		logic [7:0]                  wdat;
		logic [MEM_AW-1:0]           widx;
		logic [(1<<MEM_AW)-1:0][7:0] mem;
		logic [`AD_W-1:0]            ad_o;
		logic [1:0]                  ad_oe_n;
		logic [7:0]                  pa_o;
		logic                        pa_oe_n;
		logic [7:0]                  pb_o;
		logic                        pb_oe_n;
		logic                        arr_in;
		logic                        erd_n;
		logic                        ewr_n;
	} dev_state_s;

	dev_state_s          r;
	dev_state_s          n;
	logic                c0;
	logic                c1;
	logic                c2;
	logic                live;
	logic                rd;
	logic                wr;
	logic                sel;
	logic [`ADDR_W-1:0]  addr;
	logic [MEM_AW-1:0]   idx;
	logic [7:0]          din;
	logic [7:0]          dout;

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		n = r;
		// pins pass two flops before anything looks at them
		n.ctl_s1 = {bus.control_pin_two, bus.control_pin_one, bus.control_pin_zero};
		n.ctl_s2 = r.ctl_s1;
		n.as_s1 = bus.address_strobe;
		n.as_s2 = r.as_s1;
		n.ad_s1 = bus.address_data_port;
		n.ad_s2 = r.ad_s1;
		n.pa_s1 = bus.port_a;
		n.pa_s2 = r.pa_s1;
		n.xa_s1 = bus.extra_addr;
		n.xa_s2 = r.xa_s1;
		{c2, c1, c0} = r.ctl_s2;

		// strap caught once after release; logic waits until syncs hold real pins
		if (r.warm == '0)
			n.cfg = cfg_strap;
		if (r.warm != `WARM_DONE)
			n.warm = r.warm + 2'h1;
		live = (r.warm == `WARM_DONE);

		// strobe decode by bus type
		if (r.cfg.dir_en)
		begin
			wr = c1 & ~c0;
			rd = c1 & c0;
		end
		else
		begin
			wr = ~c0;
			// single-read: pin one alone; dual: pin one or pin two
			rd = ~c1 | (r.cfg.dual_read & ~c2);
		end

		// address latch follows the strobe level, last value held at its fall
		if (r.cfg.mux && r.as_s2)
		begin
			if (r.cfg.burst)
				n.alat = {r.ad_s2[15:12], r.ad_s2[7:0], 4'h0};
			else if (r.cfg.page)
				n.alat = {r.ad_s2[15:8], 8'h00};
			else
				n.alat = r.ad_s2;
			// single-read hosts may put A16 on port A bit zero
			if (!r.cfg.dual_read && !r.cfg.dir_en && !r.cfg.burst)
				n.xlat = {r.xa_s2[`XA_W-1:1], r.pa_s2[0]};
			else
				n.xlat = r.xa_s2;
		end

		// effective address; page and burst take the low part live
		if (!r.cfg.mux)
			addr = {r.xa_s2, r.ad_s2};
		else if (r.cfg.burst)
			addr = {r.xlat, r.alat[15:4], r.pa_s2[3:0]};
		else if (r.cfg.page)
			addr = {r.xlat, r.alat[15:8], r.ad_s2[7:0]};
		else
			addr = {r.xlat, r.alat};
		sel = live && (addr[`ADDR_W-1:MEM_AW] == BASE[`ADDR_W-1:MEM_AW]);
		// byte index includes A0, so even/odd falls out of the index
		idx = addr[MEM_AW-1:0];
		dout = r.mem[idx];

		// data lane: port A, high byte in page mode, else low byte
		if (!r.cfg.mux)
			din = r.pa_s2;
		else if (r.cfg.page)
			din = r.ad_s2[15:8];
		else
			din = r.ad_s2[7:0];

		// read drive; released on every cycle without a selected read
		n.ad_oe_n = 2'b11;
		n.pa_oe_n = 1'b1;
		if (rd && sel)
		begin
			if (!r.cfg.mux)
			begin
				n.pa_o = dout;
				n.pa_oe_n = 1'b0;
			end
			else if (r.cfg.page)
			begin
				n.ad_o[15:8] = dout;
				n.ad_oe_n = 2'b01;
			end
			else
			begin
				n.ad_o[7:0] = dout;
				n.ad_oe_n = 2'b10;
			end
		end

		// write: data tracked while strobe is active, stored at trailing edge
		if (live && wr)
		begin
			n.wr_q = sel;
			n.wdat = din;
			n.widx = idx;
		end
		else if (r.wr_q)
		begin
			n.mem[r.widx] = r.wdat;
			n.wr_q = 1'b0;
		end

		// latched address on port B for external parts
		n.pb_oe_n = ~(r.cfg.addr_out_en & live);
		n.pb_o = r.cfg.addr_out_hi ? addr[15:8] : addr[7:0];

		// pin two free in direction type or single-read: feed the logic array
		n.arr_in = (r.cfg.dir_en | ~r.cfg.dual_read) & c2;

		// chip-select decode turns E and R/W into external strobes
		n.erd_n = ~(r.cfg.dir_en & live & rd & ~sel);
		n.ewr_n = ~(r.cfg.dir_en & live & wr & ~sel);
	end

	////////////////////////////////////////////////////////////////////////////
	// state register; enables and strobes reset to released
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r <= '0;
			r.ad_oe_n <= 2'b11;
			r.pa_oe_n <= 1'b1;
			r.pb_oe_n <= 1'b1;
			r.erd_n <= 1'b1;
			r.ewr_n <= 1'b1;
		end
		else if (clk_en)
			r <= n;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign bus.ad_dev = r.ad_o;
	assign bus.ad_dev_oe_n = r.ad_oe_n;
	assign bus.pa_dev = r.pa_o;
	assign bus.pa_dev_oe_n = r.pa_oe_n;
	assign bus.port_b = r.pb_o;
	assign bus.port_b_oe_n = r.pb_oe_n;
	assign array_input = r.arr_in;
	assign ext_rd_n = r.erd_n;
	assign ext_wr_n = r.ewr_n;
endmodule
`default_nettype wire

// >>> rtl/mcu_bus_host.sv
// Purpose: host end: runs one bus cycle per command from a register port
// Assumes: read data from the device is synchronised in two flops
// Notes: page and burst hits skip the address phase
`default_nettype none
`include "mcu_bus_params.svh"
module mcu_bus_host (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic [2:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	mcu_bus_if.host          bus
);
	typedef struct packed {
		mcu_bus_pkg::cfg_s      cfg;
		mcu_bus_pkg::host_st_e  st;
		logic [3:0]             cnt;
		logic [`ADDR_W-1:0]     addr;
		logic [`ADDR_W-1:0]     last;
		logic                   hv;
		logic                   hit;
		logic [7:0]             wdata;
		logic                   rd;
		logic                   fetch;
		logic [7:0]             rdata;
		logic [`AD_W+7:0]       lane_s1;
		logic [`AD_W+7:0]       lane_s2;
		logic [2:0]             ctl;
		logic                   as;
		logic [`AD_W-1:0]       ad_o;
		logic [1:0]             ad_oe_n;
		logic [7:0]             pa_o;
		logic [7:0]             pa_oe_n;
		logic [15:0]            rdo;
	} host_state_s;

	host_state_s         r;
	host_state_s         n;
	logic [`ADDR_W-1:0]  mask;
	logic                drv;
	logic                stb;

	////////////////////////////////////////////////////////////////////////////
	// register port, bus sequencer and pin levels
	always_comb
	begin
		n = r;
		// both lanes pass two flops raw; the answering lane is picked after the second
		n.lane_s1 = {bus.port_a, bus.address_data_port};
		n.lane_s2 = r.lane_s1;
		n.rdo = 16'h0000;
		if (reg_rd)
			case (reg_addr)
				`R_CFG:     n.rdo = {9'h000, r.cfg};
				`R_ADDR_LO: n.rdo = r.addr[15:0];
				`R_ADDR_HI: n.rdo = {12'h000, r.addr[19:16]};
				`R_WDATA:   n.rdo = {8'h00, r.wdata};
				`R_RDATA:   n.rdo = {8'h00, r.rdata};
				`R_STATUS:  n.rdo = {14'h0000, r.hit, r.st != mcu_bus_pkg::H_IDLE};
				default:    n.rdo = 16'h0000;
			endcase
		// set-up registers are frozen while a cycle runs
		if (reg_wr && r.st == mcu_bus_pkg::H_IDLE)
			case (reg_addr)
				`R_CFG:     n.cfg = reg_wdata[6:0];
				`R_ADDR_LO: n.addr[15:0] = reg_wdata;
				`R_ADDR_HI: n.addr[19:16] = reg_wdata[3:0];
				`R_WDATA:   n.wdata = reg_wdata[7:0];
				default:    n.cnt = r.cnt;
			endcase
		mask = r.cfg.burst ? `BURST_MASK : `PAGE_MASK;
		n.cnt = r.cnt - 4'h1;
		case (r.st)
			mcu_bus_pkg::H_IDLE:
			begin
				n.cnt = r.cnt;
				if (reg_wr && reg_addr == `R_CMD)
				begin
					n.rd = reg_wdata[0];
					n.fetch = reg_wdata[1];
					// same page or burst block: no address strobe
					n.hit = r.cfg.mux && (r.cfg.page || r.cfg.burst) && r.hv &&
						((r.addr & mask) == (r.last & mask));
					n.st = n.hit ? mcu_bus_pkg::H_STB : mcu_bus_pkg::H_ADR;
					n.cnt = n.hit ? `H_STB_CYC : `H_ADR_CYC;
					n.last = r.addr;
					n.hv = 1'b1;
				end
			end
			mcu_bus_pkg::H_ADR:
				if (r.cnt == 4'h1)
				begin
					n.st = mcu_bus_pkg::H_HOLD;
					n.cnt = `H_HOLD_CYC;
				end
			mcu_bus_pkg::H_HOLD:
				if (r.cnt == 4'h1)
				begin
					n.st = mcu_bus_pkg::H_STB;
					n.cnt = `H_STB_CYC;
				end
			mcu_bus_pkg::H_STB:
				if (r.cnt == 4'h1)
				begin
					if (r.rd)
						n.rdata = !r.cfg.mux ? r.lane_s2[`AD_W+7:`AD_W] :
							r.cfg.page ? r.lane_s2[15:8] : r.lane_s2[7:0];
					n.st = mcu_bus_pkg::H_REC;
					n.cnt = `H_REC_CYC;
				end
			mcu_bus_pkg::H_REC:
				if (r.cnt == 4'h1)
					n.st = mcu_bus_pkg::H_IDLE;
			default:
				n.st = mcu_bus_pkg::H_IDLE;
		endcase

		// pins follow the next state so they leave flops together
		drv = (n.st != mcu_bus_pkg::H_IDLE);
		stb = (n.st == mcu_bus_pkg::H_STB);
		n.as = (n.st == mcu_bus_pkg::H_ADR) && r.cfg.mux;
		// direction from the next state: a hit strobes at the command edge itself
		if (r.cfg.dir_en)
			n.ctl = {1'b1, stb, n.rd};
		else if (r.cfg.dual_read && n.fetch)
			n.ctl = {~(stb & n.rd), 1'b1, 1'b1};
		else
			n.ctl = {1'b1, ~(stb & n.rd), ~(stb & ~n.rd)};
		if (r.cfg.mux && r.cfg.burst)
			n.ad_o = {r.addr[15:12], 4'h0, r.addr[11:4]};
		else
			n.ad_o = r.addr[15:0];
		n.pa_o = {4'h0, r.addr[3:1], r.addr[0]};
		n.pa_oe_n = 8'hff;
		n.ad_oe_n = drv ? 2'b00 : 2'b11;
		if (r.cfg.mux && r.cfg.burst)
			n.pa_oe_n = drv ? 8'hf0 : 8'hff;
		else if (r.cfg.mux && !r.cfg.dual_read && !r.cfg.dir_en)
		begin
			n.pa_o[0] = r.addr[16];
			n.pa_oe_n = drv ? 8'hfe : 8'hff;
		end
		// data phase: lane carries write data or is released for reads;
		// reads keep it released through recovery, the device lets go late
		if (stb || n.st == mcu_bus_pkg::H_REC)
		begin
			if (!r.cfg.mux)
			begin
				n.pa_o = r.wdata;
				n.pa_oe_n = n.rd ? 8'hff : 8'h00;
			end
			else if (r.cfg.page)
			begin
				n.ad_o[15:8] = r.wdata;
				n.ad_oe_n[1] = n.rd;
			end
			else
			begin
				n.ad_o[7:0] = r.wdata;
				n.ad_oe_n[0] = n.rd;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register; strobes reset inactive for strobe-type bus
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r <= '0;
			r.ctl <= 3'b111;
			r.ad_oe_n <= 2'b11;
			r.pa_oe_n <= 8'hff;
		end
		else if (clk_en)
			r <= n;
	end

	assign reg_rdata = r.rdo;
	assign bus.control_pin_zero = r.ctl[0];
	assign bus.control_pin_one = r.ctl[1];
	assign bus.control_pin_two = r.ctl[2];
	assign bus.address_strobe = r.as;
	assign bus.extra_addr = r.addr[19:16];
	assign bus.ad_host = r.ad_o;
	assign bus.ad_host_oe_n = r.ad_oe_n;
	assign bus.pa_host = r.pa_o;
	assign bus.pa_host_oe_n = r.pa_oe_n;
endmodule
`default_nettype wire

// >>> tb/mcu_bus_monitor.sv
// Purpose: concurrent checks on the pins between host and device ends
// Assumes: cfg_strap only changes while rst_n is low
// Notes: device drive lags the pins by about three edges
`default_nettype none
module mcu_bus_monitor (
	input wire logic              clk_sys,
	input wire logic              rst_n,
	input wire mcu_bus_pkg::cfg_s cfg_strap,
	input wire logic              control_pin_zero,
	input wire logic              control_pin_one,
	input wire logic              control_pin_two,
	input wire logic              address_strobe,
	input wire logic [1:0]        ad_dev_oe_n,
	input wire logic [1:0]        ad_host_oe_n,
	input wire logic              pa_dev_oe_n,
	input wire logic              port_b_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rd_pin;
	logic acc_pin;
	////////////////////////////////////////////////////////////
	// read and any access as the strapped bus type decodes the pins
	assign rd_pin = cfg_strap.dir_en ? (control_pin_zero & control_pin_one)
		: (!control_pin_one | (cfg_strap.dual_read & !control_pin_two));
	assign acc_pin = rd_pin | (cfg_strap.dir_en ? control_pin_one : !control_pin_zero);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// address phase: strobe held, then access after the hold gap
	sequence as_held;
		address_strobe [*3];
	endsequence
	sequence as_before;
		$past(address_strobe, 4) || $past(address_strobe, 5) || $past(address_strobe, 6);
	endsequence
	chk_drive_on_read: assert property (
		!(&ad_dev_oe_n && pa_dev_oe_n) |-> $past(rd_pin, 2) || $past(rd_pin, 3) || $past(rd_pin, 4))
		else $error("device drove without a read strobe");
	chk_release_after: assert property (
		$fell(rd_pin) |-> ##[1:5] (&ad_dev_oe_n && pa_dev_oe_n))
		else $error("device kept driving after read ended");
	chk_no_contention: assert property ((ad_dev_oe_n | ad_host_oe_n) == 2'h3)
		else $error("host and device drive the same byte");
	chk_page_lane: assert property (cfg_strap.page |-> ad_dev_oe_n[0])
		else $error("page mode drove the low byte");
	chk_low_lane: assert property (
		cfg_strap.mux && !cfg_strap.page |-> ad_dev_oe_n[1])
		else $error("8-bit bus drove the high byte");
	chk_nonmux_pins: assert property (!cfg_strap.mux |-> &ad_dev_oe_n)
		else $error("address port driven on a split bus");
	chk_mux_port_a: assert property (cfg_strap.mux |-> pa_dev_oe_n)
		else $error("port A driven on a shared bus");
	chk_strobe_width: assert property ($rose(address_strobe) |-> as_held)
		else $error("address strobe shorter than three cycles");
	chk_fresh_address: assert property (
		cfg_strap.mux && !cfg_strap.page && !cfg_strap.burst && $rose(acc_pin) |-> as_before)
		else $error("access without a preceding address strobe");
	chk_portb_off: assert property (!cfg_strap.addr_out_en |-> port_b_oe_n)
		else $error("port B driven while address out is off");
endmodule
`default_nettype wire

// >>> tb/mcu_bus_interface_tb.sv
// Purpose: runs host commands against the device end in each bus type
// Assumes: device memory is cleared by reset, window is 64 bytes at 0
// Notes: each bus type needs a reset since straps are caught once
`default_nettype none
`include "mcu_bus_params.svh"
module mcu_bus_interface_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk_sys;
	logic              rst_n;
	mcu_bus_pkg::cfg_s cfg_strap;
	logic [2:0]        reg_addr;
	logic [15:0]       reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [15:0]       reg_rdata;
	logic              array_input;
	logic              ext_rd_n;
	logic              ext_wr_n;
	logic              rd_seen;
	logic              wr_seen;
	logic [15:0]       got;
	int                error_cnt;
	int                cmp_count;
	////////////////////////////////////////////////////////////
	// both ends face each other; clk_en is tied, freezing is not exercised
	mcu_bus_if u_mcu_bus_if ();
	mcu_bus_port u_mcu_bus_port (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
		.cfg_strap(cfg_strap), .bus(u_mcu_bus_if), .array_input(array_input),
		.ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n));
	mcu_bus_host u_mcu_bus_host (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .bus(u_mcu_bus_if));
	mcu_bus_monitor u_mcu_bus_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
		.cfg_strap(cfg_strap), .control_pin_zero(u_mcu_bus_if.control_pin_zero),
		.control_pin_one(u_mcu_bus_if.control_pin_one),
		.control_pin_two(u_mcu_bus_if.control_pin_two),
		.address_strobe(u_mcu_bus_if.address_strobe),
		.ad_dev_oe_n(u_mcu_bus_if.ad_dev_oe_n), .ad_host_oe_n(u_mcu_bus_if.ad_host_oe_n),
		.pa_dev_oe_n(u_mcu_bus_if.pa_dev_oe_n), .port_b_oe_n(u_mcu_bus_if.port_b_oe_n));
	// 50 MHz system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// external strobes are short pulses, so latch them for later compare
	always @(negedge clk_sys)
	begin
		if (ext_rd_n === 1'b0)
			rd_seen = 1'b1;
		if (ext_wr_n === 1'b0)
			wr_seen = 1'b1;
	end
	////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic reg_read(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// one bus cycle; leaves the final status word in got
	task automatic bus_cmd(input logic [19:0] a, input logic [7:0] d, input logic [1:0] c);
		int n;
		reg_write(`R_ADDR_LO, a[15:0]);
		reg_write(`R_ADDR_HI, {12'h000, a[19:16]});
		reg_write(`R_WDATA, {8'h00, d});
		reg_write(`R_CMD, {14'h0000, c});
		n = 0;
		got = 16'h0001;
		while (got[0] !== 1'b0 && n < 60)
		begin
			reg_read(`R_STATUS, got);
			n++;
		end
		check("busy", got[0], 1'b0);
	endtask
	task automatic rd_exp(input logic [19:0] a, input logic [1:0] c, input logic [7:0] e);
		logic [15:0] st;
		bus_cmd(a, 8'h00, c);
		st = got;
		reg_read(`R_RDATA, got);
		check("rdata", got[7:0], e);
		got = st;
	endtask
	// CFG goes in at the first edge after release, before the device wakes
	task automatic restart(input mcu_bus_pkg::cfg_s c);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		cfg_strap <= c;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		reg_addr <= `R_CFG;
		reg_wdata <= {9'h000, c};
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rd_seen = 1'b0;
		wr_seen = 1'b0;
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// watchdog, far beyond the roughly 1440 cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		report_and_stop();
	end
	// main sequence: one block per bus type
	initial
	begin
		rst_n = 1'b0;
		cfg_strap = '0;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		error_cnt = 0;
		cmp_count = 0;
		// strobe type, dual read, address out on port B
		restart(7'h26);
		check("array_in", array_input, 1'b0);
		bus_cmd(20'h00005, 8'ha5, 2'b00);
		bus_cmd(20'h00004, 8'h5a, 2'b00);
		bus_cmd(20'h00045, 8'h11, 2'b00);
		rd_exp(20'h00005, 2'b01, 8'ha5);
		rd_exp(20'h00004, 2'b01, 8'h5a);
		rd_exp(20'h00045, 2'b01, 8'hff);
		rd_exp(20'h00005, 2'b11, 8'ha5);
		check("port_b", {u_mcu_bus_if.port_b_oe_n, u_mcu_bus_if.port_b}, 9'h005);
		reg_write(3'h7, 16'hffff);
		reg_read(3'h7, got);
		check("reg7", got, 16'h0000);
		// single read strobe, A16 carried on port A bit zero
		restart(7'h20);
		check("array_in", array_input, 1'b1);
		bus_cmd(20'h10007, 8'hc3, 2'b00);
		rd_exp(20'h00007, 2'b01, 8'h00);
		rd_exp(20'h10007, 2'b01, 8'hff);
		bus_cmd(20'h00007, 8'h3c, 2'b00);
		rd_exp(20'h00007, 2'b11, 8'h3c);
		// page mode: hits keep the high byte, a miss relatches it
		restart(7'h30);
		bus_cmd(20'h00010, 8'h11, 2'b00);
		bus_cmd(20'h00011, 8'h22, 2'b00);
		rd_exp(20'h00010, 2'b01, 8'h11);
		rd_exp(20'h00011, 2'b01, 8'h22);
		check("hit", got[1], 1'b1);
		rd_exp(20'h00111, 2'b01, 8'hff);
		check("hit", got[1], 1'b0);
		rd_exp(20'h00011, 2'b01, 8'h22);
		// burst: sixteen code bytes stepped on the low nibble
		restart(7'h2a);
		for (int i = 0; i < 16; i++)
			bus_cmd(20'h00020 + 20'(i), 8'h80 + 8'(i), 2'b00);
		for (int i = 0; i < 16; i++)
		begin
			rd_exp(20'h00020 + 20'(i), 2'b11, 8'h80 + 8'(i));
			if (i > 0)
				check("hit", got[1], 1'b1);
		end
		// split bus: address on the address port, data on port A
		restart(7'h04);
		bus_cmd(20'h00033, 8'h77, 2'b00);
		rd_exp(20'h00033, 2'b01, 8'h77);
		rd_exp(20'h00032, 2'b01, 8'h00);
		// direction plus enable: outside addresses raise external strobes
		restart(7'h60);
		check("array_in", array_input, 1'b1);
		bus_cmd(20'h0003f, 8'he1, 2'b00);
		rd_exp(20'h0003f, 2'b01, 8'he1);
		check("ext_rw", {rd_seen, wr_seen}, 2'b00);
		bus_cmd(20'h00080, 8'h44, 2'b00);
		rd_exp(20'h00080, 2'b01, 8'hff);
		check("ext_rw", {rd_seen, wr_seen}, 2'b11);
		rd_exp(20'h00000, 2'b01, 8'h00);
		report_and_stop();
	end
endmodule
`default_nettype wire
